// [rtl/hbfp_top.sv]
// Fault latching, output shutdown and register port of the half-bridge driver
//
// The address map and strobed register access were chosen for this implementation.
module hbfp_top
	import hbfp_pkg::*;
(
	input  wire logic              CLK_IN,        // 125 MHz clock
	input  wire logic              RST_IN,        // Sync reset, high
	input  wire logic              WR_IN,         // Write strobe
	input  wire logic              RD_IN,         // Read strobe
	input  wire logic [ADDR_W-1:0] ADDR_IN,       // Register address
	input  wire logic [DATA_W-1:0] WDATA_IN,      // Write data
	input  wire logic [NUM_HB-1:0] HS_OC_IN,      // High-side current above threshold
	input  wire logic [NUM_HB-1:0] LS_OC_IN,      // Low-side current above threshold
	input  wire logic [NUM_HB-1:0] HS_OL_IN,      // High-side current below open-load level
	input  wire logic [NUM_HB-1:0] LS_OL_IN,      // Low-side current below open-load level
	input  wire logic              TEMP_WARN_IN,  // Temperature warning level
	input  wire logic              TEMP_SD_IN,    // Temperature shutdown level
	input  wire logic              SUPPLY_UNDERVOLT_FLAG_IN,      // Supply undervoltage
	input  wire logic              SUPPLY_OVERVOLT_FLAG_IN,      // Supply overvoltage
	output logic [DATA_W-1:0]      RDATA_OUT,     // Read data, cycle after strobe
	output logic [NUM_HB-1:0]      HS_ON_OUT,     // High-side gate drive
	output logic [NUM_HB-1:0]      LS_ON_OUT,     // Low-side gate drive
	output logic [1:0]             LED_SEL_OUT,   // Low-current open-load select
	output logic                   IRQ_OUT        // Level interrupt
);
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic [7:0]        glob;
		logic [NUM_HB-1:0] hs_oc;
		logic [NUM_HB-1:0] ls_oc;
		logic [NUM_HB-1:0] hs_ol;
		logic [NUM_HB-1:0] ls_ol;
		logic [NUM_HB-1:0] hs_act;
		logic [NUM_HB-1:0] ls_act;
		logic [NUM_HB-1:0] fw;
		logic [NUM_HB-1:0] stop;
		logic [1:0]        led_sel;
		logic [7:0]        mask;
		logic              tsd_lock;
		logic [NUM_HB-1:0] hs_on;
		logic [NUM_HB-1:0] ls_on;
		logic              irq;
	} hbfp_st_t;

	hbfp_st_t    st_r;
	hbfp_st_t    st_nxt;
	hbfp_bus_t   bus;
	// A net, so each filter instance can drive its own bit of the carrier
	wire hbfp_sense_t conf;

	assign bus = '{wr: WR_IN, rd: RD_IN, addr: ADDR_IN, wdata: WDATA_IN};

	function automatic logic [NUM_HB-1:0] w1c(input logic [NUM_HB-1:0] cur, input logic [NUM_HB-1:0] set,
	                                          input logic hit, input logic [DATA_W-1:0] d);
		// Set beats clear so a fault in the clear cycle is not lost
		w1c = (cur & ~(hit ? d[NUM_HB-1:0] : '0)) | set;
	endfunction : w1c

	// Overcurrent filters on every switch; both sides guarded
	genvar g;
	for (g = 0; g < NUM_HB; g++) begin : g_flt
		hbfp_filter u_hs_oc (.clk_in(CLK_IN), .rst_in(RST_IN), .raw_in(HS_OC_IN[g] & st_r.hs_on[g]),
			.limit_in(CNT_W'(OC_FILT_CYC)), .hit_out(conf.hs_oc[g]));
		hbfp_filter u_ls_oc (.clk_in(CLK_IN), .rst_in(RST_IN), .raw_in(LS_OC_IN[g] & st_r.ls_on[g]),
			.limit_in(CNT_W'(OC_FILT_CYC)), .hit_out(conf.ls_oc[g]));
		// First two high sides use the shorter filter when LED mode is chosen
		hbfp_filter u_hs_ol (.clk_in(CLK_IN), .rst_in(RST_IN), .raw_in(HS_OL_IN[g] & st_r.hs_on[g]),
			.limit_in(((g < 2) && st_r.led_sel[g % 2]) ? CNT_W'(OL_LED_CYC) : CNT_W'(OL_FILT_CYC)),
			.hit_out(conf.hs_ol[g]));
		hbfp_filter u_ls_ol (.clk_in(CLK_IN), .rst_in(RST_IN), .raw_in(LS_OL_IN[g] & st_r.ls_on[g]),
			.limit_in(CNT_W'(OL_FILT_CYC)), .hit_out(conf.ls_ol[g]));
	end

	logic hit_glob;
	logic all_off;
	logic [NUM_HB-1:0] fw_low;

	always_comb begin
		st_nxt   = st_r;
		hit_glob = bus.wr && bus.addr == A_GLOBAL;
		// Per-switch latched flags, cleared only by a write of one
		st_nxt.hs_oc = w1c(st_r.hs_oc, conf.hs_oc, bus.wr && bus.addr == A_HS_OC, bus.wdata);
		st_nxt.ls_oc = w1c(st_r.ls_oc, conf.ls_oc, bus.wr && bus.addr == A_LS_OC, bus.wdata);
		st_nxt.hs_ol = w1c(st_r.hs_ol, conf.hs_ol, bus.wr && bus.addr == A_HS_OL, bus.wdata);
		st_nxt.ls_ol = w1c(st_r.ls_ol, conf.ls_ol, bus.wr && bus.addr == A_LS_OL, bus.wdata);
		// Global flags; hardware set wins over clear
		if (hit_glob) begin
			st_nxt.glob = st_r.glob & ~bus.wdata[7:0];
		end
		if (TEMP_WARN_IN) begin
			st_nxt.glob[B_TPW] = 1'b1;
		end
		if (TEMP_SD_IN) begin
			st_nxt.glob[B_TSD] = 1'b1;
		end
		if (SUPPLY_OVERVOLT_FLAG_IN) begin
			st_nxt.glob[B_OV] = 1'b1;
		end
		if (SUPPLY_UNDERVOLT_FLAG_IN) begin
			st_nxt.glob[B_UV] = 1'b1;
		end
		if (|{conf.hs_oc, conf.ls_oc, conf.hs_ol, conf.ls_ol}) begin
			st_nxt.glob[B_LE] = 1'b1;
		end
		st_nxt.tsd_lock = st_nxt.glob[B_TSD];
		// Control registers keep their values through every fault
		if (bus.wr) begin
			case (bus.addr)
				A_HS_ACT:   st_nxt.hs_act = bus.wdata[NUM_HB-1:0];
				A_LS_ACT:   st_nxt.ls_act = bus.wdata[NUM_HB-1:0];
				A_FW:       st_nxt.fw = bus.wdata[NUM_HB-1:0];
				A_PWM_STOP: st_nxt.stop = bus.wdata[NUM_HB-1:0];
				A_OL_SEL:   st_nxt.led_sel = bus.wdata[1:0];
				A_IRQ_MASK: st_nxt.mask = bus.wdata[7:0];
				default:    st_nxt.mask = st_r.mask;
			endcase
		end
		// Supply faults stop outputs only while present; temperature latches
		// Lock follows the flag in the same edge, so outputs never outlive a set flag
		all_off = st_nxt.tsd_lock || SUPPLY_UNDERVOLT_FLAG_IN || SUPPLY_OVERVOLT_FLAG_IN;
		// Stopped channel with active free-wheel: high side low, low side on
		fw_low = st_r.hs_act & st_r.fw & st_r.stop;
		st_nxt.hs_on = all_off ? '0 : (st_r.hs_act & ~fw_low & ~st_nxt.hs_oc);
		st_nxt.ls_on = all_off ? '0 : ((st_r.ls_act | fw_low) & ~st_nxt.ls_oc);
		st_nxt.irq = |(st_nxt.glob & st_nxt.mask);
		st_nxt.rdata = '0;
		if (bus.rd) begin
			case (bus.addr)
				A_GLOBAL:   st_nxt.rdata = DATA_W'(st_r.glob);
				A_HS_OC:    st_nxt.rdata = DATA_W'(st_r.hs_oc);
				A_LS_OC:    st_nxt.rdata = DATA_W'(st_r.ls_oc);
				A_HS_OL:    st_nxt.rdata = DATA_W'(st_r.hs_ol);
				A_LS_OL:    st_nxt.rdata = DATA_W'(st_r.ls_ol);
				A_HS_ACT:   st_nxt.rdata = DATA_W'(st_r.hs_act);
				A_LS_ACT:   st_nxt.rdata = DATA_W'(st_r.ls_act);
				A_FW:       st_nxt.rdata = DATA_W'(st_r.fw);
				A_PWM_STOP: st_nxt.rdata = DATA_W'(st_r.stop);
				A_OL_SEL:   st_nxt.rdata = DATA_W'(st_r.led_sel);
				A_IRQ_MASK: st_nxt.rdata = DATA_W'(st_r.mask);
				A_OUT_STAT: st_nxt.rdata = DATA_W'(st_r.hs_on);
				default:    st_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA_OUT   = st_r.rdata;
	assign HS_ON_OUT   = st_r.hs_on;
	assign LS_ON_OUT   = st_r.ls_on;
	assign LED_SEL_OUT = st_r.led_sel;
	assign IRQ_OUT     = st_r.irq;

	// Assertions
	chk_oc_keeps_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		st_r.hs_oc != '0 |-> (st_r.hs_on & st_r.hs_oc) == '0) else $error("high side on with oc flag");
	chk_tsd_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		st_r.glob[B_TSD] |-> st_r.hs_on == '0 && st_r.ls_on == '0) else $error("outputs on during tsd");
	chk_uv_latch: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		SUPPLY_UNDERVOLT_FLAG_IN |=> st_r.glob[B_UV] && st_r.hs_on == '0) else $error("uv not handled");
	chk_ov_latch: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		SUPPLY_OVERVOLT_FLAG_IN |=> st_r.glob[B_OV] && st_r.ls_on == '0) else $error("ov not handled");
	chk_tpw_latch: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		TEMP_WARN_IN |=> st_r.glob[B_TPW]) else $error("prewarn not set");
	chk_le_global: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(st_r.hs_oc | st_r.ls_oc | st_r.hs_ol | st_r.ls_ol) != '0 && $past(st_r.hs_oc) == st_r.hs_oc
		&& !$past(hit_glob) |-> st_r.glob[B_LE]) else $error("load error flag missing");
	chk_fw_low: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!all_off && (fw_low & ~st_nxt.ls_oc) != '0
		|=> (st_r.hs_on & $past(fw_low)) == '0
		&& (st_r.ls_on & $past(fw_low & ~st_nxt.ls_oc)) == $past(fw_low & ~st_nxt.ls_oc))
		else $error("free-wheel wrong");
	chk_ol_no_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!all_off && st_r.hs_act[0] && !fw_low[0] && !st_nxt.hs_oc[0] |=> st_r.hs_on[0]) else $error("open load changed output");
	chk_rd_latency: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!bus.rd |=> st_r.rdata == '0) else $error("read data outside slot");

	// Overcurrent: confirmed filter hit, then flag latched, switch off and load error raised
	sequence s_oc_hit;
		(conf.hs_oc | conf.ls_oc) != '0;
	endsequence
	sequence s_oc_latched;
		(st_r.hs_oc & $past(conf.hs_oc)) == $past(conf.hs_oc)
		&& (st_r.ls_oc & $past(conf.ls_oc)) == $past(conf.ls_oc)
		&& (st_r.hs_on & st_r.hs_oc) == '0 && (st_r.ls_on & st_r.ls_oc) == '0
		&& st_r.glob[B_LE];
	endsequence
	chk_oc_latch_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		s_oc_hit |=> s_oc_latched) else $error("overcurrent not latched off");
endmodule : hbfp_top

// [rtl/hbfp_pkg.sv]
// Package of constants and carrier types for the half-bridge fault protection block
// How it works
// - Stopped PWM with active free-wheel: high side held low, adjacent low side on.
// - Two LED selection bits pick lower open-load threshold and shorter filter.
// - Overcurrent beyond filter time latches switch off and sets its flag.
// - Load-error flag at global status bit 6 set by any overcurrent or open-load.
// - Overcurrent switch stays off while flag set; clearing flag reactivates it.
// - Per-switch overcurrent flags and open-load flags kept in latched registers.
// - Open load sets its latched flag and the load-error flag only; outputs unchanged until controller clears.
// - Temperature warning sets latched pre-warning at bit 1, outputs unchanged.
// - Temperature shutdown sets bit 2, all outputs off until flag cleared.
// - Undervoltage sets bit 5, outputs off until supply recovers, flag stays.
// - Overvoltage sets bit 4, outputs off until supply recovers, flag stays.
// - High side guarded against short to ground, low side against short to supply.
// - Pre-warning stays latched until cleared; output stages stay active meanwhile.
package hbfp_pkg;
	localparam int NUM_HB = 10;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// Register map
	localparam logic [3:0] A_GLOBAL   = 4'h0;
	localparam logic [3:0] A_HS_OC    = 4'h1;
	localparam logic [3:0] A_LS_OC    = 4'h2;
	localparam logic [3:0] A_HS_OL    = 4'h3;
	localparam logic [3:0] A_LS_OL    = 4'h4;
	localparam logic [3:0] A_HS_ACT   = 4'h5;
	localparam logic [3:0] A_LS_ACT   = 4'h6;
	localparam logic [3:0] A_FW       = 4'h7;
	localparam logic [3:0] A_PWM_STOP = 4'h8;
	localparam logic [3:0] A_OL_SEL   = 4'h9;
	localparam logic [3:0] A_IRQ_MASK = 4'hA;
	localparam logic [3:0] A_OUT_STAT = 4'hB;
	// Global status bits
	localparam int B_TPW = 1;
	localparam int B_TSD = 2;
	localparam int B_OV  = 4;
	localparam int B_UV  = 5;
	localparam int B_LE  = 6;
	// Overcurrent filter time and open-load filter times, ns
	localparam int CLK_NS       = 8;
	localparam int OC_FILT_NS   = 64;
	localparam int OL_FILT_NS   = 400;
	localparam int OL_LED_NS    = 96;
	localparam int OC_FILT_CYC  = (OC_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int OL_FILT_CYC  = (OL_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int OL_LED_CYC   = (OL_LED_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 8;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} hbfp_bus_t;

	typedef struct packed {
		logic [NUM_HB-1:0] hs_oc;
		logic [NUM_HB-1:0] ls_oc;
		logic [NUM_HB-1:0] hs_ol;
		logic [NUM_HB-1:0] ls_ol;
	} hbfp_sense_t;
endpackage : hbfp_pkg

// [rtl/hbfp_filter.sv]
// Filter that asserts its output after the input has been high for a set number of cycles
module hbfp_filter
	import hbfp_pkg::*;
(
	input  wire logic             clk_in,    // Clock
	input  wire logic             rst_in,    // Sync reset
	input  wire logic             raw_in,    // Raw comparator level
	input  wire logic [CNT_W-1:0] limit_in,  // Cycles to confirm
	output logic                  hit_out    // Held while confirmed
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             hit;
	} hbfp_flt_st_t;

	hbfp_flt_st_t st_r;
	hbfp_flt_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (!raw_in) begin
			st_nxt.cnt = '0;
			st_nxt.hit = 1'b0;
		end else if (st_r.cnt + CNT_W'(1) >= limit_in) begin
			st_nxt.hit = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hit_out = st_r.hit;
endmodule : hbfp_filter

// [sim/hbfp_mcu.sv]
// Controller model that reads and clears flags over the register port
module hbfp_mcu
	import hbfp_pkg::*;
(
	input  wire logic              clk_in,    // Clock
	input  wire logic [DATA_W-1:0] rdata_in,  // Read data
	output logic                   wr_out,    // Write strobe
	output logic                   rd_out,    // Read strobe
	output logic [ADDR_W-1:0]      addr_out,  // Address
	output logic [DATA_W-1:0]      wdata_out  // Write data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 4'h0;
		wdata_out = 16'h0000;
	end
	// Released lines show the inverse so a stale value never looks valid
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		d = rdata_in;
	endtask : rd
endmodule : hbfp_mcu

// [sim/hbfp_tb_top.sv]
// Self-checking bench for the fault protection block
module hbfp_tb_top
	import hbfp_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [NUM_HB-1:0] hs_oc = '0, ls_oc = '0, hs_ol = '0, ls_ol = '0, hs_on, ls_on;
	logic              twarn = 1'b0, temp_shutdown_flag = 1'b0, uv = 1'b0, ov = 1'b0, wr, rd, irq;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [1:0]        led;
	int                failures = 0;
	int                tests_run = 0;
	always #4 clk = ~clk;
	hbfp_mcu i_mcu (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
	hbfp_top i_dut (.CLK_IN(clk), .RST_IN(rst), .WR_IN(wr), .RD_IN(rd), .ADDR_IN(addr), .WDATA_IN(wdata),
		.HS_OC_IN(hs_oc), .LS_OC_IN(ls_oc), .HS_OL_IN(hs_ol), .LS_OL_IN(ls_ol), .TEMP_WARN_IN(twarn),
		.TEMP_SD_IN(temp_shutdown_flag), .SUPPLY_UNDERVOLT_FLAG_IN(uv), .SUPPLY_OVERVOLT_FLAG_IN(ov), .RDATA_OUT(rdata), .HS_ON_OUT(hs_on),
		.LS_ON_OUT(ls_on), .LED_SEL_OUT(led), .IRQ_OUT(irq));
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rc(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] d;
		i_mcu.rd(a, d);
		chk(what, exp, d);
	endtask : rc
	task automatic clks(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : clks
	function automatic logic on_of(input logic ls, input int i);
		return ls ? ls_on[i] : hs_on[i];
	endfunction : on_of
	task automatic wait_on(input logic ls, input int i, input logic v, output int n);
		n = 0;
		while (on_of(ls, i) !== v && n < 100) begin
			clks(1);
			n++;
		end
		if (n >= 100) begin
			failures++;
			close_out();
		end
	endtask : wait_on
	task automatic cond(input int b, input logic v);
		@(posedge clk);
		case (b)
			B_TPW: twarn <= v;
			B_TSD: temp_shutdown_flag <= v;
			B_UV: uv <= v;
			default: ov <= v;
		endcase
	endtask : cond
	task automatic t_oc(input logic ls, input int i);
		int n;
		logic [DATA_W-1:0] m;
		m = 16'h0001 << i;
		i_mcu.wr(ls ? A_LS_ACT : A_HS_ACT, m);
		wait_on(ls, i, 1'b1, n);
		@(posedge clk);
		hs_oc[i] <= !ls;
		ls_oc[i] <= ls;
		#1;
		wait_on(ls, i, 1'b0, n);
		chk("oc delay", 16'h0001, 16'(n >= OC_FILT_CYC && n <= OC_FILT_CYC + 4));
		rc("oc flag", ls ? A_LS_OC : A_HS_OC, m);
		rc("load error", A_GLOBAL, 16'h0040);
		@(posedge clk);
		hs_oc[i] <= 1'b0;
		ls_oc[i] <= 1'b0;
		clks(20);
		chk("held off", 16'h0000, 16'(on_of(ls, i)));
		i_mcu.wr(ls ? A_LS_OC : A_HS_OC, m);
		i_mcu.wr(A_GLOBAL, 16'h0040);
		wait_on(ls, i, 1'b1, n);
		rc("oc clear", ls ? A_LS_OC : A_HS_OC, 16'h0000);
		rc("le clear", A_GLOBAL, 16'h0000);
		i_mcu.wr(ls ? A_LS_ACT : A_HS_ACT, 16'h0000);
	endtask : t_oc
	task automatic t_ol(input logic ls, input int i, input int f);
		logic [DATA_W-1:0] m;
		logic [ADDR_W-1:0] fa;
		m = 16'h0001 << i;
		fa = ls ? A_LS_OL : A_HS_OL;
		i_mcu.wr(ls ? A_LS_ACT : A_HS_ACT, m);
		clks(4);
		@(posedge clk);
		hs_ol[i] <= !ls;
		ls_ol[i] <= ls;
		clks(f + 4);
		rc("ol flag", fa, m);
		rc("ol le", A_GLOBAL, 16'h0040);
		chk("ol out on", 16'h0001, 16'(on_of(ls, i)));
		i_mcu.wr(fa, m);
		clks(f + 8);
		rc("ol again", fa, m);
		@(posedge clk);
		hs_ol[i] <= 1'b0;
		ls_ol[i] <= 1'b0;
		i_mcu.wr(fa, m);
		i_mcu.wr(A_GLOBAL, 16'h0040);
		rc("ol clear", fa, 16'h0000);
		i_mcu.wr(ls ? A_LS_ACT : A_HS_ACT, 16'h0000);
	endtask : t_ol
	task automatic t_glob(input int b, input logic kill, input logic back);
		logic [DATA_W-1:0] m;
		m = 16'h0001 << b;
		i_mcu.wr(A_HS_ACT, 16'h0001);
		i_mcu.wr(A_IRQ_MASK, m);
		cond(b, 1'b1);
		clks(4);
		rc("glob flag", A_GLOBAL, m);
		chk("glob out", 16'(!kill), 16'(hs_on[0]));
		chk("irq set", 16'h0001, 16'(irq));
		i_mcu.wr(A_IRQ_MASK, 16'h0000);
		cond(b, 1'b0);
		clks(4);
		chk("irq masked", 16'h0000, 16'(irq));
		chk("glob back", 16'(!kill || back), 16'(hs_on[0]));
		rc("glob held", A_GLOBAL, m);
		i_mcu.wr(A_GLOBAL, m);
		clks(3);
		chk("glob on", 16'h0001, 16'(hs_on[0]));
		rc("glob clear", A_GLOBAL, 16'h0000);
		i_mcu.wr(A_HS_ACT, 16'h0000);
	endtask : t_glob
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		clks(1);
		chk("out rst", 16'h0000, {3'h0, irq, led, hs_on | ls_on});
		i_mcu.wr(4'hE, 16'hFFFF);
		for (int a = 0; a < 5; a++) rc("rst reg", 4'(a), 16'h0000);
		rc("unmapped", 4'hF, 16'h0000);
		t_oc(1'b0, 0);
		t_oc(1'b1, 9);
		t_ol(1'b0, 4, OL_FILT_CYC);
		t_ol(1'b1, 7, OL_FILT_CYC);
		i_mcu.wr(A_PWM_STOP, 16'h0001);
		i_mcu.wr(A_HS_ACT, 16'h0001);
		i_mcu.wr(A_OL_SEL, 16'h0003);
		i_mcu.wr(A_PWM_STOP, 16'h0000);
		clks(3);
		chk("led select", 16'h0003, 16'(led));
		t_ol(1'b0, 1, OL_LED_CYC);
		i_mcu.wr(A_OL_SEL, 16'h0000);
		i_mcu.wr(A_FW, 16'h0004);
		i_mcu.wr(A_PWM_STOP, 16'h0004);
		i_mcu.wr(A_HS_ACT, 16'h0004);
		clks(3);
		chk("fw hs", 16'h0000, 16'(hs_on[2]));
		chk("fw ls", 16'h0001, 16'(ls_on[2]));
		t_glob(B_TPW, 1'b0, 1'b0);
		t_glob(B_TSD, 1'b1, 1'b0);
		t_glob(B_UV, 1'b1, 1'b1);
		t_glob(B_OV, 1'b1, 1'b1);
		close_out();
	end
endmodule : hbfp_tb_top
